// ==== hw/contact_monitor_pkg.sv ====
// Purpose: Shared constants of the contact monitor serial port and registers
// Assumes: 100 MHz core clock
// Notes: Times kept in their own unit, cycle counts derived from them
package contact_monitor_pkg;

    localparam int CLK_MHZ = 100;
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_BITS_C = 5'h10;

    // Command word field positions
    localparam int CMD_HOLD_BIT = 15;
    localparam int CMD_SEL_HI = 14;
    localparam int CMD_SEL_LO = 12;
    localparam int CMD_WEN_BIT = 11;
    localparam int CMD_LOW_PAIR_BIT = 10;
    localparam int CMD_UPPER_BIT = 9;
    localparam int CMD_MIDDLE_BIT = 8;
    localparam int CMD_MASK_HI = 7;
    localparam logic [15:0] CMD_RESET = 16'h0000;

    // Status word field positions
    localparam int STAT_CONTACT_LO = 8;
    localparam int STAT_HEAT_BIT = 7;
    localparam logic [6:0] STAT_UNUSED = 7'h00;

    // Scan interval codes
    localparam logic [2:0] SEL_CONT_FIXED_HYST = 3'h6;
    localparam logic [2:0] SEL_FIRST_CONT = 3'h6;
    localparam logic [31:0] SCAN_MS_LONGEST = 32'h0000_0040;

    // Timing: figure as printed, then cycles
    localparam int POLL_US = 250;
    localparam int WET_MS = 20;
    localparam int SCAN_UNIT_MS = 1;
    localparam int POLL_CYC_DEF = POLL_US * CLK_MHZ;
    localparam int WET_CYC_DEF = WET_MS * 1000 * CLK_MHZ;
    localparam int MS_CYC_DEF = SCAN_UNIT_MS * 1000 * CLK_MHZ;

endpackage

// ==== hw/contact_monitor_serial_regs.sv ====
// Purpose: Serial slave port, status and command words, scan and wetting
// Assumes: Serial pins are asynchronous; switch states and heat come from
//          logic on the core clock
// Notes: Serial clock is oversampled, so it must stay well below core clock
//
// Contract
// R1 - Sixteen-bit status out, command in, MSB first
// R2 - Chip-select fall loads status, rising clock shifts
// R3 - Falling serial clock samples data in
// R4 - Chip-select rise copies shift register to command
// R5 - Master gives exactly sixteen clocks per frame
// R6 - Deselected: data out released, pins ignored
// R7 - Chip-select fall releases interrupt and heat alert
// R8 - Changes during frame still raise interrupt
// R9 - Status high byte shows switch states
// R10 - Status bit seven shows overheat level
// R11 - Master ignores status bits six to zero
// R12 - Command word resets to zero
// R13 - Hold mode bit: continuous or 20ms wetting
// R14 - Periodic scan wets only during poll
// R15 - Interval field selects period or continuous
// R16 - Periodic scan polls all inputs together
// R17 - Continuous codes keep sense resistors connected
// R18 - Code six fixes hysteresis, adjustable off
// R19 - Global wetting enable, upper sense stays
// R20 - Low pair sense and wetting enable
// R21 - Low pair direct outputs in continuous only
// R22 - Low pair status frozen while disabled
// R23 - Pair polarity bits for inputs seven to four
// R24 - Mask bits disable per-input interrupts
// R25 - Reset state is 64ms periodic scan
// R26 - Command updates only after sixteen clocks
module contact_monitor_serial_regs
    import contact_monitor_pkg::*;
#(
    parameter int POLL_CYC = POLL_CYC_DEF,
    parameter int WET_CYC = WET_CYC_DEF,
    parameter int MS_CYC = MS_CYC_DEF
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    input wire logic [7:0] contact_state_bits,
    input wire logic overheat_flag,
    input wire logic [1:0] contact_lines,
    output logic int_out,
    output logic int_oe_n,
    output logic heat_out,
    output logic heat_oe_n,
    output logic [7:0] wetting_on,
    output logic [7:0] sense_on,
    output logic [1:0] direct_level_outputs,
    output logic direct_oe_n,
    output logic hyst_fixed,
    output logic upper_pair_polarity,
    output logic middle_pair_polarity
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic cs_m;
        logic cs_s;
        logic cs_p;
        logic ck_m;
        logic ck_s;
        logic ck_p;
        logic di_m;
        logic di_s;
        logic [1:0] dl_m;
        logic [1:0] dl_s;
        logic [15:0] shreg;
        logic [4:0] cnt;
        logic [15:0] cmd;
        logic [7:0] contact;
        logic heat_p;
        logic int_oe_n;
        logic heat_oe_n;
        logic sdo;
        logic sdo_oe_n;
        logic [31:0] per_cnt;
        logic [31:0] wet_cnt;
        logic [7:0] wet;
        logic [7:0] sense;
        logic [1:0] dout;
        logic dout_oe_n;
        logic hyst_fixed;
        logic upper;
        logic middle;
    } state_t;

    state_t s_q;
    state_t s_d;

    localparam state_t STATE_RESET = '{
        cs_m: 1'b1, cs_s: 1'b1, cs_p: 1'b1,
        ck_m: 1'b0, ck_s: 1'b0, ck_p: 1'b0,
        di_m: 1'b0, di_s: 1'b0,
        dl_m: 2'h0, dl_s: 2'h0,
        shreg: 16'h0000, cnt: 5'h00, cmd: CMD_RESET,
        contact: 8'h00, heat_p: 1'b0,
        int_oe_n: 1'b1, heat_oe_n: 1'b1,
        sdo: 1'b0, sdo_oe_n: 1'b1,
        per_cnt: 32'h0000_0000, wet_cnt: 32'h0000_0000,
        wet: 8'h00, sense: 8'h00, dout: 2'h0, dout_oe_n: 1'b1,
        hyst_fixed: 1'b0, upper: 1'b0, middle: 1'b0
    };

    // Scan period in cycles; code 0 is the longest, each step halves it
    function automatic logic [31:0] period_of(input logic [2:0] code);
        logic [31:0] ms;
        ms = SCAN_MS_LONGEST >> code;
        return ms * 32'(MS_CYC);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic cs_fall;
    logic cs_rise;
    logic ck_rise;
    logic ck_fall;
    logic [2:0] sel;
    logic periodic;
    logic poll;
    logic wen;
    logic low_pair;
    logic wet_time;
    logic wet_gate;
    logic int_event;
    logic heat_event;
    logic [7:0] contact_d;
    logic [15:0] status_word;

    always_comb begin
        s_d = s_q;
        // Two-flop synchronisers for all serial and raw pins
        s_d.cs_m = cs_n;
        s_d.cs_s = s_q.cs_m;
        s_d.cs_p = s_q.cs_s;
        s_d.ck_m = sclk;
        s_d.ck_s = s_q.ck_m;
        s_d.ck_p = s_q.ck_s;
        s_d.di_m = sdi;
        s_d.di_s = s_q.di_m;
        s_d.dl_m = contact_lines;
        s_d.dl_s = s_q.dl_m;

        cs_fall = s_q.cs_p & ~s_q.cs_s;
        cs_rise = ~s_q.cs_p & s_q.cs_s;
        // Clock edges count only inside a frame, not on its first cycle
        ck_rise = ~s_q.cs_s & ~s_q.cs_p & ~s_q.ck_p & s_q.ck_s; // [R6]
        ck_fall = ~s_q.cs_s & ~s_q.cs_p & s_q.ck_p & ~s_q.ck_s; // [R6]

        sel = s_q.cmd[CMD_SEL_HI:CMD_SEL_LO];
        periodic = sel < SEL_FIRST_CONT; // [R15] [R25]
        wen = s_q.cmd[CMD_WEN_BIT];
        low_pair = s_q.cmd[CMD_LOW_PAIR_BIT];

        // Low pair status held while configured as direct inputs
        contact_d[7:2] = contact_state_bits[7:2]; // [R9]
        contact_d[1:0] = low_pair ? contact_state_bits[1:0]
                                  : s_q.contact[1:0]; // [R22]
        s_d.contact = contact_d;

        status_word = {s_q.contact, overheat_flag, STAT_UNUSED}; // [R9] [R10]

        // Serial shifting
        if (cs_fall) begin
            s_d.shreg = status_word; // [R2]
            s_d.cnt = 5'h00;
            s_d.sdo = status_word[FRAME_BITS-1];
        end else begin
            if (ck_rise) begin
                s_d.sdo = s_q.shreg[FRAME_BITS-1]; // [R1] [R2]
            end
            if (ck_fall) begin
                s_d.shreg = {s_q.shreg[FRAME_BITS-2:0], s_q.di_s}; // [R3]
                if (s_q.cnt != 5'h1f) begin
                    s_d.cnt = s_q.cnt + 5'h01;
                end
            end
        end
        // Short or long frames leave the command word untouched
        if (cs_rise && s_q.cnt == FRAME_BITS_C) begin
            s_d.cmd = s_q.shreg; // [R4] [R26]
        end
        s_d.sdo_oe_n = s_q.cs_s; // [R6]

        // Alerts: a new event in the clearing cycle wins
        int_event = |((contact_d ^ s_q.contact)
                      & ~s_q.cmd[CMD_MASK_HI:0]); // [R24] [R8]
        heat_event = overheat_flag & ~s_q.heat_p;
        s_d.heat_p = overheat_flag;
        if (int_event) begin
            s_d.int_oe_n = 1'b0; // [R8]
        end else if (cs_fall) begin
            s_d.int_oe_n = 1'b1; // [R7]
        end
        if (heat_event) begin
            s_d.heat_oe_n = 1'b0;
        end else if (cs_fall) begin
            s_d.heat_oe_n = 1'b1; // [R7]
        end

        // Scan period counter and poll window
        if (!periodic || s_q.per_cnt >= period_of(sel) - 32'h1) begin
            s_d.per_cnt = 32'h0000_0000;
        end else begin
            s_d.per_cnt = s_q.per_cnt + 32'h1;
        end
        poll = periodic && s_q.per_cnt < 32'(POLL_CYC); // [R16]

        // One shared pulse timer, restarted by any new closure
        if (|(contact_d & ~s_q.contact)) begin
            s_d.wet_cnt = 32'(WET_CYC); // [R13]
        end else if (s_q.wet_cnt != 32'h0) begin
            s_d.wet_cnt = s_q.wet_cnt - 32'h1;
        end
        wet_time = s_q.cmd[CMD_HOLD_BIT] | (s_q.wet_cnt != 32'h0); // [R13]
        wet_gate = wet_time & (~periodic | poll); // [R14]
        s_d.wet[7:2] = {6{wen & wet_gate}} & contact_d[7:2]; // [R19]
        s_d.wet[1:0] = {2{wen & low_pair & wet_gate}}
                       & contact_d[1:0]; // [R20]

        // Sense resistors: always on in continuous, poll-only in scan; low pair only with its enable
        s_d.sense[7:2] = {6{~periodic | poll}}; // [R16] [R17] [R19]
        s_d.sense[1:0] = {2{low_pair & (~periodic | poll)}}; // [R20]

        // Direct outputs only in continuous mode with the low pair off
        s_d.dout = s_q.dl_s;
        s_d.dout_oe_n = periodic | low_pair; // [R21]

        s_d.hyst_fixed = sel == SEL_CONT_FIXED_HYST; // [R18]
        s_d.upper = s_q.cmd[CMD_UPPER_BIT]; // [R23]
        s_d.middle = s_q.cmd[CMD_MIDDLE_BIT]; // [R23]
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= STATE_RESET; // [R12]
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Open-drain pins only ever pull low
    assign int_out = 1'b0;
    assign heat_out = 1'b0;
    assign sdo = s_q.sdo;
    assign sdo_oe_n = s_q.sdo_oe_n;
    assign int_oe_n = s_q.int_oe_n;
    assign heat_oe_n = s_q.heat_oe_n;
    assign wetting_on = s_q.wet;
    assign sense_on = s_q.sense;
    assign direct_level_outputs = s_q.dout;
    assign direct_oe_n = s_q.dout_oe_n;
    assign hyst_fixed = s_q.hyst_fixed;
    assign upper_pair_polarity = s_q.upper;
    assign middle_pair_polarity = s_q.middle;

    ////////////////////////////////////////////////////////////////////////
    property p_sdo_released;
        @(posedge clock) disable iff (rst || !clk_en)
        s_q.cs_s ##1 s_q.cs_s |-> sdo_oe_n;
    endproperty
    a_sdo_released: assert property (p_sdo_released) // [R6]
        else $error("data out driven while deselected");

    property p_load_status;
        @(posedge clock) disable iff (rst || !clk_en)
        cs_fall |=> s_q.shreg == {$past(s_q.contact), $past(overheat_flag),
                                  STAT_UNUSED};
    endproperty
    a_load_status: assert property (p_load_status) // [R2]
        else $error("status not loaded at select fall");

    property p_sdo_shift;
        @(posedge clock) disable iff (rst || !clk_en)
        ck_rise |=> sdo == $past(s_q.shreg[FRAME_BITS-1]);
    endproperty
    a_sdo_shift: assert property (p_sdo_shift) // [R2]
        else $error("data out did not follow shift register");

    property p_shift_in;
        @(posedge clock) disable iff (rst || !clk_en)
        ck_fall |=> s_q.shreg[0] == $past(s_q.di_s);
    endproperty
    a_shift_in: assert property (p_shift_in) // [R3]
        else $error("data in not shifted at clock fall");

    property p_cmd_update;
        @(posedge clock) disable iff (rst || !clk_en)
        cs_rise && s_q.cnt == FRAME_BITS_C |=> s_q.cmd == $past(s_q.shreg);
    endproperty
    a_cmd_update: assert property (p_cmd_update) // [R4]
        else $error("command not taken after full frame");

    property p_cmd_keep;
        @(posedge clock) disable iff (rst || !clk_en)
        cs_rise && s_q.cnt != FRAME_BITS_C |=> $stable(s_q.cmd);
    endproperty
    a_cmd_keep: assert property (p_cmd_keep) // [R26]
        else $error("command changed after bad frame");

    property p_int_release;
        @(posedge clock) disable iff (rst || !clk_en)
        cs_fall && !int_event |=> int_oe_n && heat_oe_n == !$past(heat_event);
    endproperty
    a_int_release: assert property (p_int_release) // [R7]
        else $error("alerts not released at select fall");

    property p_int_set;
        @(posedge clock) disable iff (rst || !clk_en)
        int_event |=> !int_oe_n;
    endproperty
    a_int_set: assert property (p_int_set) // [R8]
        else $error("unmasked change did not raise interrupt");

    property p_sense_cont;
        @(posedge clock) disable iff (rst || !clk_en)
        !periodic ##1 !periodic |-> sense_on[7:2] == 6'h3f;
    endproperty
    a_sense_cont: assert property (p_sense_cont) // [R17]
        else $error("sense off in continuous mode");

    property p_wet_off;
        @(posedge clock) disable iff (rst || !clk_en)
        !wen |=> wetting_on == 8'h00;
    endproperty
    a_wet_off: assert property (p_wet_off) // [R19]
        else $error("wetting on with global enable clear");

    property p_direct_oe;
        @(posedge clock) disable iff (rst || !clk_en)
        (periodic || low_pair) |=> direct_oe_n;
    endproperty
    a_direct_oe: assert property (p_direct_oe) // [R21]
        else $error("direct outputs driven in wrong mode");

    property p_low_hold;
        @(posedge clock) disable iff (rst || !clk_en)
        !low_pair |=> s_q.contact[1:0] == $past(s_q.contact[1:0]);
    endproperty
    a_low_hold: assert property (p_low_hold) // [R22]
        else $error("low pair status moved while disabled");

endmodule // contact_monitor_serial_regs

// ==== bench/contact_monitor_master.sv ====
// Purpose: Serial master model that runs frames against the contact monitor
// Assumes: sclk period is eight core cycles, idle low between frames
// Notes: Data line toggles every cycle between frames, so no stale level
module contact_monitor_master (
    input wire logic clock,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    output logic cs_n,
    output logic sclk,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 1ps;

    logic idle = 1'b1;
    logic sdo_w;

    // Released data out has no pull, so it shows the inverse level
    assign sdo_w = sdo_oe_n ? ~sdo : sdo;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    always @(posedge clock) begin
        if (idle) begin
            sdi <= ~sdi;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit is read as the clock falls, after the rise that moved it out
    task automatic frame(input logic [15:0] tx, input int n,
                         output logic [15:0] rx);
        idle = 1'b0;
        rx = 16'h0000;
        @(posedge clock);
        cs_n <= 1'b0;
        repeat (8) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            sclk <= 1'b1;
            sdi <= tx[15 - i];
            repeat (4) @(posedge clock);
            rx = {rx[14:0], sdo_w};
            sclk <= 1'b0;
            repeat (4) @(posedge clock);
        end
        rx = rx & 16'hff80;
        cs_n <= 1'b1;
        repeat (8) @(posedge clock);
        idle = 1'b1;
    endtask

    // Pin activity while deselected; ends with sclk low
    task automatic noise(input int n);
        idle = 1'b0;
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge clock);
            sclk <= ~sclk;
            sdi <= ~sdi;
            repeat (3) @(posedge clock);
        end
        idle = 1'b1;
    endtask
endmodule // contact_monitor_master

// ==== bench/contact_monitor_serial_regs_tb_top.sv ====
// Purpose: Self-checking bench for the contact monitor serial port
// Assumes: Short timing parameters, 640-cycle longest scan period
// Notes: Outputs are sampled at falling core clock edges
module contact_monitor_serial_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock, rst, cs_n, sclk, sdi, sdo, sdo_oe_n, overheat_flag;
    logic int_oe_n, heat_oe_n, direct_oe_n, hyst_fixed;
    logic int_out, heat_out;
    logic upper_pair_polarity, middle_pair_polarity;
    logic [7:0] contact, wetting_on, sense_on;
    logic [1:0] contact_lines, direct_level_outputs;
    logic [6:0] flags;
    logic [15:0] rx;
    int miscompares = 0;
    int checked = 0;
    int s, w;

    assign flags = {int_oe_n, heat_oe_n, sdo_oe_n, direct_oe_n, hyst_fixed,
                    upper_pair_polarity, middle_pair_polarity};

    contact_monitor_serial_regs #(.POLL_CYC(5), .WET_CYC(50), .MS_CYC(10))
    i_dut (.clock(clock), .rst(rst), .clk_en(1'b1), .cs_n(cs_n),
        .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .contact_state_bits(contact), .overheat_flag(overheat_flag),
        .contact_lines(contact_lines), .int_out(int_out),
        .int_oe_n(int_oe_n), .heat_out(heat_out), .heat_oe_n(heat_oe_n),
        .wetting_on(wetting_on),
        .sense_on(sense_on), .direct_level_outputs(direct_level_outputs),
        .direct_oe_n(direct_oe_n), .hyst_fixed(hyst_fixed),
        .upper_pair_polarity(upper_pair_polarity),
        .middle_pair_polarity(middle_pair_polarity));

    contact_monitor_master i_master (.clock(clock), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Whole number of periods for every code, so phase does not matter
    task automatic count();
        s = 0;
        w = 0;
        repeat (640) begin
            @(negedge clock);
            s += int'(sense_on[7]);
            w += int'(wetting_on[7]);
        end
    endtask

    task automatic settle(input logic [7:0] c, input logic heat);
        @(posedge clock);
        contact <= c;
        overheat_flag <= heat;
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        contact = 8'h00;
        overheat_flag = 1'b0;
        contact_lines = 2'b00;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        @(negedge clock);
        check(16'(flags), 16'h0078);
        count();
        check(16'(s), 16'h0005);
        check(16'(w), 16'h0000);
        settle(8'ha5, 1'b1);
        check(16'(flags[6:5]), 16'h0000);
        i_master.frame(16'h0000, 16, rx);
        check(rx, 16'ha480);
        @(negedge clock);
        check(16'(flags[6:5]), 16'h0003);
        check(16'({int_out, heat_out}), 16'h0000);
        i_master.frame(16'hef00, 15, rx);
        @(negedge clock);
        check(16'(flags), 16'h0078);
        i_master.noise(6);
        i_master.frame(16'hef00, 16, rx);
        check(rx, 16'ha480);
        @(negedge clock);
        check(16'(flags[5:0]), 16'h003f);
        check(16'(sense_on), 16'h00ff);
        check(16'(wetting_on), 16'h00a5);
        @(posedge clock);
        contact_lines <= 2'b10;
        i_master.frame(16'h7000, 16, rx);
        @(negedge clock);
        check(16'(flags), 16'h0070);
        check(16'(sense_on), 16'h00fc);
        check(16'(wetting_on), 16'h0000);
        check(16'(direct_level_outputs), 16'h0002);
        settle(8'ha4, 1'b0);
        check(16'(int_oe_n), 16'h0001);
        i_master.frame(16'h7080, 16, rx);
        check(rx, 16'ha500);
        settle(8'h24, 1'b0);
        check(16'(int_oe_n), 16'h0001);
        fork
            i_master.frame(16'h7880, 16, rx);
            begin
                repeat (40) @(posedge clock);
                contact <= 8'h2c;
            end
        join
        @(negedge clock);
        check(16'(int_oe_n), 16'h0000);
        settle(8'h6c, 1'b0);
        check(16'(wetting_on), 16'h006c);
        repeat (60) @(negedge clock);
        check(16'(wetting_on), 16'h0000);
        settle(8'hec, 1'b0);
        for (int code = 0; code < 6; code++) begin
            i_master.frame({1'b1, 3'(code), 12'h800}, 16, rx);
            count();
            check(16'(s), 16'(5 << code));
            check(16'(w), 16'(5 << code));
        end
        results();
    end

    // Hang guard
    initial begin
        #300us;
        miscompares++;
        results();
    end
endmodule // contact_monitor_serial_regs_tb_top
